// >>> verilog/genset_pkg.sv
`default_nettype none
package genset_pkg;
    localparam int CLK_HZ   = 125_000_000;
    localparam int TICK_S   = 1;
    localparam int TICK_CYC = CLK_HZ * TICK_S;

    localparam int          COOL_MAX_MIN = 30;
    localparam logic [10:0] COOL_MAX_S   = 11'(COOL_MAX_MIN * 60 / TICK_S);
    localparam int          PD_S         = 70;
    localparam logic [6:0]  PD_TICKS     = 7'(PD_S / TICK_S);

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_COOL   = 8'h04;
    localparam logic [7:0] OFS_CRANK  = 8'h08;
    localparam logic [7:0] OFS_SPEED  = 8'h0c;
    localparam logic [7:0] OFS_OIL    = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_FAULT  = 8'h18;

    localparam int CTL_W     = 4;
    localparam int C_FUEL_INV = 0;
    localparam int C_LOP_OVR = 1;
    localparam int C_HWT_OVR = 2;
    localparam int C_AIR     = 3;
    localparam int CR_ON_LSB   = 0;
    localparam int CR_REST_LSB = 8;
    localparam int CR_MAX_LSB  = 16;
    localparam int SPD_OVS_LSB = 16;

    localparam logic [CTL_W-1:0] CTL_RST       = 4'h0;
    localparam logic [10:0]      COOL_RST      = 11'h000;
    localparam logic [7:0]       CRANK_ON_RST  = 8'h0a;
    localparam logic [7:0]       CRANK_REST_RST = 8'h0a;
    localparam logic [3:0]       CRANK_MAX_RST = 4'h3;
    localparam logic [15:0]      TERM_RST      = 16'h0190;
    localparam logic [15:0]      OVS_RST       = 16'hffff;
    localparam logic [15:0]      OIL_RST       = 16'h0064;

    localparam int PIN_W  = 12;
    localparam int P_AUTO = 0;
    localparam int P_MAN  = 1;
    localparam int P_STOP = 2;
    localparam int P_OFF  = 3;
    localparam int P_REM  = 4;
    localparam int P_ESTOP = 5;
    localparam int P_HIFUEL = 6;
    localparam int P_PRUN = 7;
    localparam int P_PSTOP = 8;
    localparam int P_JUMP = 9;
    localparam int P_HWT  = 10;
    localparam int P_LCL  = 11;

    localparam int FLT_W   = 6;
    localparam int F_LOP   = 0;
    localparam int F_ESTOP = 1;
    localparam int F_HWT   = 2;
    localparam int F_OVS   = 3;
    localparam int F_LCL   = 4;
    localparam int F_OVC   = 5;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_CRANK = 5'h02,
        S_REST  = 5'h04,
        S_RUN   = 5'h08,
        S_COOL  = 5'h10
    } seq_state_t;

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] prev;
        seq_state_t       st;
        logic [15:0]      tmr;
        logic [3:0]       tries;
        logic [31:0]      pre;
        logic             tick;
        logic [6:0]       pdCnt;
        logic [FLT_W-1:0] flt;
        logic             pumpOn;
        logic             stopLatch;
        logic [CTL_W-1:0] ctl;
        logic [10:0]      cool;
        logic [7:0]       crankOn;
        logic [7:0]       crankRest;
        logic [3:0]       crankMax;
        logic [15:0]      termSpd;
        logic [15:0]      overSpd;
        logic [15:0]      oilSet;
        logic             fuelOut;
        logic             starterOut;
        logic             govRaise;
        logic             airShut;
        logic             pdOk;
        logic             shutLamp;
        logic             almLamp;
        logic             ack;
        logic [31:0]      dat;
    } core_t;
endpackage
`default_nettype wire

// >>> verilog/genset_start_stop_sequencer.sv
`default_nettype none
module genset_start_stop_sequencer
    import genset_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatIn,
    output var  logic [31:0] wbDatOut,
    output var  logic        wbAck,
    input  wire logic [15:0] engineSpeed,
    input  wire logic [15:0] oilPressure,
    input  wire logic        modeAutoPin,
    input  wire logic        modeManualPin,
    input  wire logic        modeStopPin,
    input  wire logic        modeOffPin,
    input  wire logic        remoteRun,
    input  wire logic        emergencyStopButton,
    input  wire logic        highFuelLevel,
    input  wire logic        pumpRunButton,
    input  wire logic        pumpStopButton,
    input  wire logic        powerDownJumper,
    input  wire logic        highWaterTemp,
    input  wire logic        lowCoolantLevel,
    output var  logic        fuelSolenoid,
    output var  logic        starterMotor,
    output var  logic        governorRaise,
    output var  logic        airShutoff,
    output var  logic        transferPump,
    output var  logic        pumpRunLamp,
    output var  logic        pumpStopLamp,
    output var  logic        shutdownLamp,
    output var  logic        alarmLamp,
    output var  logic [5:0]  faultReport,
    output var  logic        powerDownPermit
);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    core_t            r;
    core_t            n;
    logic [PIN_W-1:0] pins;
    logic [3:0]       modeBits;
    logic             isAuto;
    logic             isMan;
    logic             isOff;
    logic             runReq;
    logic             kill;
    logic             runEdge;
    logic             stopEdge;
    logic             pdIdle;
    logic [FLT_W-1:0] newF;
    logic [FLT_W-1:0] ovr;
    logic [31:0]      cur;
    logic [31:0]      wd;

    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] wr,
                                              input logic [3:0]  sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                m[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return m;
    endfunction

    assign pins = {lowCoolantLevel, highWaterTemp, powerDownJumper, pumpStopButton,
                   pumpRunButton, highFuelLevel, emergencyStopButton, remoteRun,
                   modeOffPin, modeStopPin, modeManualPin, modeAutoPin};

    always_comb
    begin
        n = r;
        n.s1 = pins;
        n.s2 = r.s1;
        n.prev = r.s2;

        // Shared one-second tick
        n.tick = 1'b0;
        if (r.pre >= TICK_LAST)
        begin
            n.pre = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.pre = r.pre + 32'h1;
        end

        // Invalid selector combinations fall back to stop
        modeBits = {r.s2[P_OFF], r.s2[P_STOP], r.s2[P_MAN], r.s2[P_AUTO]};
        isAuto = (modeBits == 4'h1);
        isMan = (modeBits == 4'h2);
        isOff = (modeBits == 4'h8);
        runReq = (isAuto && r.s2[P_REM]) || isMan;

        newF = '0;
        newF[F_ESTOP] = r.s2[P_ESTOP];
        newF[F_HWT] = r.s2[P_HWT];
        newF[F_LCL] = r.s2[P_LCL];
        newF[F_OVS] = (engineSpeed > r.overSpd);
        // Oil only judged after governor raise, avoiding a trip at idle
        newF[F_LOP] = r.govRaise && (oilPressure < r.oilSet);
        ovr = '0;
        ovr[F_LOP] = r.ctl[C_LOP_OVR];
        ovr[F_HWT] = r.ctl[C_HWT_OVR];
        // New events win over the off/reset clear
        n.flt = (isOff ? '0 : r.flt) | newF;
        kill = |(n.flt & ~ovr) || isOff;

        case (r.st)
            S_IDLE:
            begin
                if (runReq && !kill)
                begin
                    n.st = S_CRANK;
                    n.tmr = {8'h00, r.crankOn};
                    n.tries = 4'h1;
                end
            end
            S_CRANK:
            begin
                if (kill || !runReq)
                begin
                    n.st = S_IDLE;
                end
                else if (engineSpeed >= r.termSpd)
                begin
                    n.st = S_RUN;
                end
                else if (r.tmr == 16'h0)
                begin
                    if (r.tries >= r.crankMax)
                    begin
                        n.st = S_IDLE;
                        n.flt[F_OVC] = 1'b1;
                    end
                    else
                    begin
                        n.st = S_REST;
                        n.tmr = {8'h00, r.crankRest};
                    end
                end
                else if (r.tick)
                begin
                    n.tmr = r.tmr - 16'h1;
                end
            end
            S_REST:
            begin
                if (kill || !runReq)
                begin
                    n.st = S_IDLE;
                end
                else if (r.tmr == 16'h0)
                begin
                    n.st = S_CRANK;
                    n.tmr = {8'h00, r.crankOn};
                    n.tries = r.tries + 4'h1;
                end
                else if (r.tick)
                begin
                    n.tmr = r.tmr - 16'h1;
                end
            end
            S_RUN:
            begin
                if (kill)
                begin
                    n.st = S_IDLE;
                end
                else if (!runReq)
                begin
                    n.st = S_COOL;
                    n.tmr = {5'h00, r.cool};
                end
            end
            S_COOL:
            begin
                if (kill)
                begin
                    n.st = S_IDLE;
                end
                else if (runReq)
                begin
                    n.st = S_RUN;
                end
                else if (r.tmr == 16'h0)
                begin
                    n.st = S_IDLE;
                end
                else if (r.tick)
                begin
                    n.tmr = r.tmr - 16'h1;
                end
            end
            default:
            begin
                n.st = S_IDLE;
            end
        endcase

        n.fuelOut = (n.st inside {S_CRANK, S_RUN, S_COOL}) ^ r.ctl[C_FUEL_INV];
        n.starterOut = (n.st == S_CRANK);
        n.govRaise = (n.st inside {S_RUN, S_COOL})
                     && (r.govRaise || oilPressure > r.oilSet);
        n.airShut = r.s2[P_ESTOP] && r.ctl[C_AIR];
        n.shutLamp = |(n.flt & ~ovr);
        n.almLamp = |(n.flt & ovr);

        runEdge = r.s2[P_PRUN] && !r.prev[P_PRUN];
        stopEdge = r.s2[P_PSTOP] && !r.prev[P_PSTOP];
        n.stopLatch = r.stopLatch ^ stopEdge;
        n.pumpOn = (r.pumpOn || runEdge) && !n.stopLatch
                   && !r.s2[P_HIFUEL];

        // Both relays are off in idle and in rest; the permit waits for idle
        pdIdle = isOff && !r.s2[P_JUMP] && (r.st == S_IDLE);
        if (!pdIdle)
        begin
            n.pdCnt = '0;
        end
        else if (r.tick && r.pdCnt != PD_TICKS)
        begin
            n.pdCnt = r.pdCnt + 7'h1;
        end
        n.pdOk = pdIdle && (n.pdCnt == PD_TICKS);

        case (wbAdr)
            OFS_CTRL:   cur = {28'h0, r.ctl};
            OFS_COOL:   cur = {21'h0, r.cool};
            OFS_CRANK:  cur = {12'h0, r.crankMax, r.crankRest, r.crankOn};
            OFS_SPEED:  cur = {r.overSpd, r.termSpd};
            OFS_OIL:    cur = {16'h0, r.oilSet};
            OFS_STATUS: cur = {19'h0, r.stopLatch, r.pumpOn, r.pdOk, r.airShut,
                               r.almLamp, r.govRaise, r.starterOut, r.fuelOut, r.st};
            OFS_FAULT:  cur = {26'h0, r.flt};
            default:    cur = 32'h0;
        endcase
        wd = laneMerge(cur, wbDatIn, wbSel);

        n.ack = wbCyc && wbStb && !r.ack;
        if (n.ack && !wbWe)
        begin
            n.dat = cur;
        end
        // Writes land on the edge at which the master samples ack
        if (r.ack && wbCyc && wbStb && wbWe)
        begin
            case (wbAdr)
                OFS_CTRL:
                begin
                    n.ctl = wd[CTL_W-1:0];
                end
                OFS_COOL:
                begin
                    // Out-of-range writes saturate at the longest cooldown
                    if (|wd[31:11] || wd[10:0] > COOL_MAX_S)
                    begin
                        n.cool = COOL_MAX_S;
                    end
                    else
                    begin
                        n.cool = wd[10:0];
                    end
                end
                OFS_CRANK:
                begin
                    n.crankOn = wd[CR_ON_LSB +: 8];
                    n.crankRest = wd[CR_REST_LSB +: 8];
                    n.crankMax = wd[CR_MAX_LSB +: 4];
                end
                OFS_SPEED:
                begin
                    n.termSpd = wd[15:0];
                    n.overSpd = wd[SPD_OVS_LSB +: 16];
                end
                OFS_OIL:
                begin
                    n.oilSet = wd[15:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.st <= S_IDLE;
            r.ctl <= CTL_RST;
            r.cool <= COOL_RST;
            r.crankOn <= CRANK_ON_RST;
            r.crankRest <= CRANK_REST_RST;
            r.crankMax <= CRANK_MAX_RST;
            r.termSpd <= TERM_RST;
            r.overSpd <= OVS_RST;
            r.oilSet <= OIL_RST;
        end
        else if (ce)
        begin
            r <= n;
        end
    end

    assign wbDatOut = r.dat;
    assign wbAck = r.ack;
    assign fuelSolenoid = r.fuelOut;
    assign starterMotor = r.starterOut;
    assign governorRaise = r.govRaise;
    assign airShutoff = r.airShut;
    assign transferPump = r.pumpOn;
    assign pumpRunLamp = r.pumpOn;
    assign pumpStopLamp = r.stopLatch;
    assign shutdownLamp = r.shutLamp;
    assign alarmLamp = r.almLamp;
    assign faultReport = r.flt;
    assign powerDownPermit = r.pdOk;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_crankEntry;
        r.st == S_IDLE ##1 r.st == S_CRANK;
    endsequence
    sequence s_runOpen;
        ce && r.st == S_RUN && !runReq && !kill;
    endsequence

    property p_startBoth;
        s_crankEntry |-> r.starterOut && (r.fuelOut != r.ctl[C_FUEL_INV]);
    endproperty
    a_startBoth: assert property (p_startBoth) else $error("start without fuel");

    property p_autoStart;
        ce && isAuto && r.s2[P_REM] && r.st == S_IDLE && !kill |=> r.st == S_CRANK;
    endproperty
    a_autoStart: assert property (p_autoStart) else $error("no auto start");

    property p_crankTerm;
        ce && r.st == S_CRANK && runReq && !kill && engineSpeed >= r.termSpd
            |=> r.st == S_RUN && !r.starterOut;
    endproperty
    a_crankTerm: assert property (p_crankTerm) else $error("starter held");

    property p_coolStart;
        s_runOpen |=> r.st == S_COOL && r.tmr == {5'h00, r.cool};
    endproperty
    a_coolStart: assert property (p_coolStart) else $error("no cooldown");

    property p_offNow;
        ce && isOff |=> r.st == S_IDLE && !r.starterOut;
    endproperty
    a_offNow: assert property (p_offNow) else $error("off not immediate");

    property p_coolMax;
        r.cool <= COOL_MAX_S;
    endproperty
    a_coolMax: assert property (p_coolMax) else $error("cooldown over limit");

    property p_pdWait;
        // Permit was judged on the jumper level one cycle earlier
        r.pdOk |-> r.pdCnt == PD_TICKS && r.st == S_IDLE && !$past(r.s2[P_JUMP]);
    endproperty
    a_pdWait: assert property (p_pdWait) else $error("early power down");

    property p_jumper;
        ce && r.s2[P_JUMP] |=> !r.pdOk;
    endproperty
    a_jumper: assert property (p_jumper) else $error("jumper ignored");

    property p_shutBlock;
        ce && |(n.flt & ~ovr) |=> r.st == S_IDLE;
    endproperty
    a_shutBlock: assert property (p_shutBlock) else $error("fault not stopped");

    property p_highFuel;
        ce && r.s2[P_HIFUEL] |=> !r.pumpOn;
    endproperty
    a_highFuel: assert property (p_highFuel) else $error("pump past high level");

    property p_stopLatch;
        ce && r.stopLatch && !(r.s2[P_PSTOP] && !r.prev[P_PSTOP]) |=> r.stopLatch && !r.pumpOn;
    endproperty
    a_stopLatch: assert property (p_stopLatch) else $error("latch lost");

    property p_estop;
        ce && r.s2[P_ESTOP] |=> r.st == S_IDLE && (r.airShut == r.ctl[C_AIR]);
    endproperty
    a_estop: assert property (p_estop) else $error("estop not honoured");
endmodule
`default_nettype wire

// >>> bench/engine_model.sv
`default_nettype none
module engine_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        fuelSolenoid,
    input  wire logic        starterMotor,
    input  wire logic        invFuel,
    input  wire logic        noFire,
    input  wire logic        slow,
    output var  logic [15:0] engineSpeed,
    output var  logic [15:0] oilPressure
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fueled;
    assign fueled = fuelSolenoid ^ invFuel;
    // A dead engine only turns over on the starter, never reaches release speed
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            engineSpeed <= 16'h0000;
        else if (!fueled)
            engineSpeed <= (engineSpeed > 16'h0020) ? engineSpeed - 16'h0020 : 16'h0000;
        else if (starterMotor && noFire)
            engineSpeed <= 16'h0050;
        else if ((starterMotor || engineSpeed > 16'h00c8) && engineSpeed < 16'h0320)
            engineSpeed <= engineSpeed + (slow ? 16'h0008 : 16'h0020);
    end
    // Pressure lags speed so the governor request trails starter release
    assign oilPressure = (engineSpeed >= 16'h0258) ? 16'h00c8 : 16'h0000;
endmodule
`default_nettype wire

// >>> bench/genset_start_stop_sequencer_tb.sv
`default_nettype none
module genset_start_stop_sequencer_tb
    import genset_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FU = 0, ST = 1, GV = 2, AI = 3, PU = 4, RL = 5, SL = 6, SD = 7, AL = 8, PD = 9;
    logic             clk, nrst, wbCyc, wbStb, wbWe, wbAck, invFuel, noFire, slow;
    logic [7:0]       wbAdr;
    logic [31:0]      wbDatIn, wbDatOut, rd;
    logic [15:0]      engineSpeed, oilPressure;
    logic [PIN_W-1:0] pin;
    logic [5:0]       faultReport;
    wire logic [9:0]  outs;
    int               n_mismatch, tests_run;

    genset_start_stop_sequencer #(.TICK_CYCLES(10)) u_dut (
        .clk, .nrst, .ce(1'b1), .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel(4'hf), .wbDatIn,
        .wbDatOut, .wbAck, .engineSpeed, .oilPressure, .modeAutoPin(pin[P_AUTO]),
        .modeManualPin(pin[P_MAN]), .modeStopPin(pin[P_STOP]), .modeOffPin(pin[P_OFF]),
        .remoteRun(pin[P_REM]), .emergencyStopButton(pin[P_ESTOP]),
        .highFuelLevel(pin[P_HIFUEL]), .pumpRunButton(pin[P_PRUN]),
        .pumpStopButton(pin[P_PSTOP]), .powerDownJumper(pin[P_JUMP]),
        .highWaterTemp(pin[P_HWT]), .lowCoolantLevel(pin[P_LCL]), .fuelSolenoid(outs[FU]),
        .starterMotor(outs[ST]), .governorRaise(outs[GV]), .airShutoff(outs[AI]),
        .transferPump(outs[PU]), .pumpRunLamp(outs[RL]), .pumpStopLamp(outs[SL]),
        .shutdownLamp(outs[SD]), .alarmLamp(outs[AL]), .faultReport,
        .powerDownPermit(outs[PD]));
    engine_model u_eng (.clk, .nrst, .fuelSolenoid(outs[FU]), .starterMotor(outs[ST]),
        .invFuel, .noFire, .slow, .engineSpeed, .oilPressure);

    task automatic finish_test();
        $display("mismatches=%0d checks=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic waitOut(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (outs[i] !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        chk(32'(outs[i]), 32'(v));
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatIn <= d;
        @(posedge clk);
        while (wbAck !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(wbAck), 32'h1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic setPin(input int i, input logic v);
        @(posedge clk);
        pin[i] <= v;
    endtask
    task automatic setMode(input logic [3:0] m);
        @(posedge clk);
        pin[3:0] <= m;
    endtask
    task automatic press(input int i);
        setPin(i, 1'b1);
        repeat (4) @(posedge clk);
        setPin(i, 1'b0);
        repeat (4) @(posedge clk);
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic startManual();
        setMode(4'h2);
        waitOut(ST, 1'b1, 8);
        waitOut(ST, 1'b0, 200);
    endtask

    task automatic regsAtReset();
        logic [7:0]  a [6];
        logic [31:0] e [6];
        a = '{OFS_CTRL, OFS_COOL, OFS_CRANK, OFS_SPEED, OFS_OIL, 8'h40};
        e = '{32'(CTL_RST), 32'(COOL_RST), {12'h0, CRANK_MAX_RST, CRANK_REST_RST, CRANK_ON_RST},
              {OVS_RST, TERM_RST}, 32'(OIL_RST), 32'h0};
        chk(32'(outs), 32'h0);
        for (int i = 0; i < 6; i++)
            rdChk(a[i], e[i]);
        wb(1'b1, 8'h40, 32'hffff_ffff);
        rdChk(8'h40, 32'h0);
        wb(1'b1, OFS_COOL, 32'h0000_07ff);
        rdChk(OFS_COOL, 32'(COOL_MAX_S));
    endtask
    task automatic autoRun();
        wb(1'b1, OFS_COOL, 32'h3);
        setMode(4'h1);
        setPin(P_REM, 1'b1);
        waitOut(ST, 1'b1, 8);
        waitOut(FU, 1'b1, 0);
        waitOut(ST, 1'b0, 100);
        chk(32'(engineSpeed >= TERM_RST), 32'h1);
        waitOut(GV, 1'b1, 100);
        chk(32'(oilPressure > OIL_RST), 32'h1);
        setPin(P_REM, 1'b0);
        idle(16);
        waitOut(FU, 1'b1, 0);
        waitOut(FU, 1'b0, 30);
        idle(60);
    endtask
    task automatic manualStop();
        wb(1'b1, OFS_COOL, 32'h2);
        slow <= 1'b1;
        startManual();
        idle(80);
        waitOut(FU, 1'b1, 0);
        setMode(4'h6);
        slow <= 1'b0;
        idle(10);
        waitOut(FU, 1'b1, 0);
        waitOut(FU, 1'b0, 30);
        idle(60);
    endtask
    task automatic offNow();
        wb(1'b1, OFS_COOL, 32'h1e);
        startManual();
        setMode(4'h8);
        waitOut(FU, 1'b0, 4);
        idle(40);
    endtask
    task automatic estop();
        wb(1'b1, OFS_CTRL, 32'h8);
        startManual();
        setPin(P_ESTOP, 1'b1);
        waitOut(FU, 1'b0, 4);
        waitOut(AI, 1'b1, 2);
        waitOut(SD, 1'b1, 2);
        chk(32'(faultReport), 32'h2);
        rdChk(OFS_FAULT, 32'h0000_0002);
        setPin(P_ESTOP, 1'b0);
        idle(40);
        waitOut(ST, 1'b0, 0);
        waitOut(FU, 1'b0, 0);
        setMode(4'h8);
        idle(5);
        chk(32'(faultReport), 32'h0);
        waitOut(SD, 1'b0, 0);
    endtask
    task automatic faults();
        wb(1'b1, OFS_CTRL, 32'h4);
        startManual();
        setPin(P_HWT, 1'b1);
        idle(6);
        waitOut(AL, 1'b1, 0);
        waitOut(FU, 1'b1, 0);
        setPin(P_LCL, 1'b1);
        waitOut(FU, 1'b0, 5);
        chk(32'(faultReport), 32'h14);
        setPin(P_HWT, 1'b0);
        setPin(P_LCL, 1'b0);
        setMode(4'h8);
        idle(40);
    endtask
    task automatic overcrank();
        int   starts;
        logic prev;
        starts = 0;
        prev = 1'b0;
        wb(1'b1, OFS_CRANK, 32'h0002_0102);
        noFire <= 1'b1;
        setMode(4'h2);
        repeat (150)
        begin
            @(negedge clk);
            if (outs[ST] && !prev)
                starts++;
            prev = outs[ST];
        end
        chk(32'(starts), 32'h2);
        chk(32'(faultReport), 32'h20);
        setMode(4'h8);
        noFire <= 1'b0;
        idle(10);
    endtask
    task automatic overspeed();
        wb(1'b1, OFS_SPEED, {16'h0300, TERM_RST});
        startManual();
        waitOut(FU, 1'b0, 40);
        chk(32'(faultReport), 32'h8);
        wb(1'b1, OFS_SPEED, {OVS_RST, TERM_RST});
        setMode(4'h8);
        idle(40);
    endtask
    task automatic powerDown();
        idle(750);
        waitOut(PD, 1'b0, 0);
        setPin(P_JUMP, 1'b0);
        idle(600);
        waitOut(PD, 1'b0, 0);
        waitOut(PD, 1'b1, 150);
        setPin(P_JUMP, 1'b1);
        waitOut(PD, 1'b0, 5);
    endtask
    task automatic polarity();
        wb(1'b1, OFS_CTRL, 32'h1);
        invFuel <= 1'b1;
        idle(2);
        waitOut(FU, 1'b1, 0);
        startManual();
        waitOut(FU, 1'b0, 0);
        setMode(4'h8);
        waitOut(FU, 1'b1, 5);
        wb(1'b1, OFS_CTRL, 32'h0);
        invFuel <= 1'b0;
        idle(40);
    endtask
    task automatic pump();
        press(P_PRUN);
        waitOut(PU, 1'b1, 0);
        waitOut(RL, 1'b1, 0);
        setPin(P_HIFUEL, 1'b1);
        waitOut(PU, 1'b0, 5);
        setPin(P_HIFUEL, 1'b0);
        press(P_PRUN);
        press(P_PSTOP);
        waitOut(PU, 1'b0, 0);
        waitOut(SL, 1'b1, 0);
        press(P_PRUN);
        waitOut(PU, 1'b0, 0);
        press(P_PSTOP);
        waitOut(SL, 1'b0, 0);
        press(P_PRUN);
        waitOut(PU, 1'b1, 0);
        rdChk(OFS_STATUS, 32'h0000_0801);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        nrst = 1'b0;
        {wbCyc, wbStb, wbWe, invFuel, noFire, slow} = '0;
        wbAdr = 8'h00;
        wbDatIn = 32'h0;
        pin = '0;
        pin[P_JUMP] = 1'b1;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        regsAtReset();
        autoRun();
        manualStop();
        offNow();
        estop();
        faults();
        overspeed();
        overcrank();
        powerDown();
        polarity();
        pump();
        finish_test();
    end
    // Whole run needs about 2500 cycles; a hung wait must not hide
    initial
    begin
        #200us;
        n_mismatch++;
        finish_test();
    end
endmodule
`default_nettype wire
